/* hdl/amcs_top.v */
// mux select and conversion sequencer with two-wire slave and wishbone
//
// The implementer's own choices: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
`include "amcs_regs.vh"
module amcs_top #(
   parameter [188:0] ADDR_TABLE = `AMCS_ADDR_TABLE_DEF
) (
   input wire clk,
   input wire rst,
   input wire [1:0] addr_strap_0,
   input wire [1:0] addr_strap_1,
   input wire [1:0] addr_strap_2,
   input wire scl_i,
   input wire sda_i,
   output reg sda_o,
   output reg sda_oe_n,
   output reg conv_start,
   input wire res_valid,
   output wire res_ready,
   input wire res_sign,
   input wire res_ovr,
   input wire [15:0] res_value,
   output reg [16:0] mux_pos_en,
   output reg [16:0] mux_neg_en,
   output reg polarity_flag_out,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [3:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o
);
   // sequencer states
   localparam [1:0] D_CONV = 2'h0;
   localparam [1:0] D_SLEEP = 2'h1;
   localparam [1:0] D_OUT = 2'h2;
   // two-wire slave states
   localparam [1:0] I_IDLE = 2'h0;
   localparam [1:0] I_ADDR = 2'h1;
   localparam [1:0] I_WDAT = 2'h2;
   localparam [1:0] I_RDAT = 2'h3;

   // sense code to digit: low 0, high 1, anything else floating 2
   function [4:0] strap_digit;
      input [1:0] code;
      begin
         if (code == `AMCS_STRAP_LOW)
            strap_digit = 5'h00;
         else if (code == `AMCS_STRAP_HIGH)
            strap_digit = 5'h01;
         else
            strap_digit = 5'h02;
      end
   endfunction

   reg [1:0] dev_q; // sequencer state
   reg [1:0] i2c_q; // bus slave state
   reg [4:0] sel_q; // last written selection
   reg [6:0] own_addr_q; // strap address
   reg strap_done_q; // straps caught since reset
   reg [1:0] ctrl_q; // control register
   reg scl_q; // previous clock sample
   reg sda_q; // previous data sample
   reg [3:0] bit_cnt_q; // clock rises in current byte
   reg [7:0] rx_q; // received byte
   reg [23:0] tx_q; // result shifter
   reg [4:0] tx_cnt_q; // result bits sent
   reg addressed_q; // address acked, cleared at stop or after a full read
   reg rw_q; // read request held
   reg start_pend_q; // conversion owed
   reg [23:0] last_res_q; // result for software
   reg pop_q; // drain buffer head
   reg [4:0] strap_idx; // table row
   wire scl_rise; // bus clock rising
   wire scl_fall; // bus clock falling
   wire bus_start; // start condition
   wire bus_stop; // stop condition
   wire addr_hit; // address matches
   wire [23:0] res_word; // framed result
   wire buf_valid; // buffer head present
   wire [23:0] buf_data; // buffer head word
   wire [16:0] dec_pos; // decoded positive
   wire [16:0] dec_neg; // decoded negative
   wire wb_req; // bus cycle pending

   assign scl_rise = scl_i & ~scl_q;
   assign scl_fall = ~scl_i & scl_q;
   assign bus_start = scl_i & scl_q & sda_q & ~sda_i;
   assign bus_stop = scl_i & scl_q & ~sda_q & sda_i;
   assign addr_hit = (rx_q[7:1] == own_addr_q) |
      (ctrl_q[`AMCS_CTRL_GLOBAL_EN] &
      (rx_q[7:1] == `AMCS_GLOBAL_ADDR));
   assign res_word = {res_sign, res_ovr, res_value, 6'h00};
   assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

   // result buffer between converter and bus
   amcs_fifo2 #(
      .WIDTH(24)
   ) u_buf (
      .clk(clk),
      .rst(rst),
      .in_valid(res_valid),
      .in_ready(res_ready),
      .in_data(res_word),
      .out_valid(buf_valid),
      .out_ready(pop_q),
      .out_data(buf_data)
   );

   // selection decode
   amcs_mux_dec u_dec (
      .sel(sel_q),
      .pos_en(dec_pos),
      .neg_en(dec_neg)
   );

   // table row from the three strap digits
   always @*
   begin
      strap_idx = strap_digit(addr_strap_2) * 5'h09 +
         strap_digit(addr_strap_1) * 5'h03 + strap_digit(addr_strap_0);
   end

   // straps caught once after reset release
   always @(posedge clk)
   begin
      if (rst)
      begin
         strap_done_q <= 1'b0;
         own_addr_q <= 7'h00;
      end
      else if (!strap_done_q)
      begin
         strap_done_q <= 1'b1;
         own_addr_q <= ADDR_TABLE[strap_idx * 7 +: 7];
      end
   end

   // bus slave and conversion sequencer
   always @(posedge clk)
   begin
      if (rst)
      begin
         dev_q <= D_CONV;
         i2c_q <= I_IDLE;
         sel_q <= `AMCS_SEL_RESET;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         sda_o <= 1'b0;
         sda_oe_n <= 1'b1;
         bit_cnt_q <= 4'h0;
         rx_q <= 8'h00;
         tx_q <= 24'h000000;
         tx_cnt_q <= 5'h00;
         addressed_q <= 1'b0;
         rw_q <= 1'b0;
         start_pend_q <= 1'b1; // first conversion at power-up
         conv_start <= 1'b0;
         pop_q <= 1'b0;
         mux_pos_en <= 17'h00000;
         mux_neg_en <= 17'h00000;
         last_res_q <= 24'h000000;
         polarity_flag_out <= 1'b0;
      end
      else
      begin
         scl_q <= scl_i;
         sda_q <= sda_i;
         conv_start <= 1'b0;
         pop_q <= 1'b0;
         // launch a conversion on the latched selection
         if (start_pend_q && !wb_req)
         begin
            start_pend_q <= 1'b0;
            conv_start <= 1'b1;
            dev_q <= D_CONV;
            mux_pos_en <= dec_pos;
            mux_neg_en <= dec_neg;
            pop_q <= buf_valid;
         end
         else if (dev_q == D_CONV && buf_valid && !pop_q)
         begin
            dev_q <= D_SLEEP;
            last_res_q <= buf_data;
            polarity_flag_out <= buf_data[23];
         end
         else if (wb_req && wb_we_i && wb_sel_i[0] &&
            wb_adr_i == `AMCS_OFS_CTRL && dev_q == D_SLEEP &&
            wb_dat_i[`AMCS_CTRL_FORCE])
            start_pend_q <= 1'b1;
         if (wb_req && wb_we_i && wb_sel_i[0] &&
            wb_adr_i == `AMCS_OFS_CHSEL)
            sel_q <= wb_dat_i[4:0];
         if (bus_stop)
         begin
            // stop ends output or a write: new conversion
            i2c_q <= I_IDLE;
            sda_oe_n <= 1'b1;
            if (addressed_q && dev_q != D_CONV)
               start_pend_q <= 1'b1;
            addressed_q <= 1'b0;
         end
         else if (bus_start)
         begin
            i2c_q <= I_ADDR;
            bit_cnt_q <= 4'h0;
            sda_oe_n <= 1'b1;
         end
         else if (i2c_q != I_IDLE && scl_rise)
         begin
            if (bit_cnt_q != `AMCS_BYTE_BITS)
            begin
               bit_cnt_q <= bit_cnt_q + 4'h1;
               rx_q <= {rx_q[6:0], sda_i};
               if (i2c_q == I_RDAT)
               begin
                  tx_q <= {tx_q[22:0], 1'b0};
                  tx_cnt_q <= tx_cnt_q + 5'h01;
               end
            end
            else
            begin
               // ninth clock of a byte
               bit_cnt_q <= 4'h0;
               case (i2c_q)
                  I_ADDR:
                  begin
                     if (!sda_oe_n && rw_q)
                     begin
                        i2c_q <= I_RDAT;
                        dev_q <= D_OUT;
                        tx_q <= last_res_q;
                        tx_cnt_q <= 5'h00;
                     end
                     else if (!sda_oe_n)
                        i2c_q <= I_WDAT;
                     else
                        i2c_q <= I_IDLE;
                  end
                  I_RDAT:
                  begin
                     if (tx_cnt_q == `AMCS_RES_BITS)
                     begin
                        i2c_q <= I_IDLE;
                        addressed_q <= 1'b0;
                        start_pend_q <= 1'b1;
                     end
                     else if (sda_i)
                        i2c_q <= I_IDLE; // master not acknowledging
                  end
                  default:
                     i2c_q <= i2c_q;
               endcase
            end
         end
         else if (i2c_q != I_IDLE && scl_fall)
         begin
            if (bit_cnt_q == `AMCS_BYTE_BITS)
            begin
               // drive the acknowledge slot
               case (i2c_q)
                  I_ADDR:
                  begin
                     rw_q <= rx_q[0];
                     if (addr_hit && dev_q != D_CONV)
                     begin
                        sda_oe_n <= 1'b0;
                        addressed_q <= 1'b1;
                     end
                     else
                        sda_oe_n <= 1'b1; // NAK while converting
                  end
                  I_WDAT:
                  begin
                     sda_oe_n <= 1'b0;
                     if (rx_q[7:5] == `AMCS_PRE_LOAD)
                        sel_q <= rx_q[4:0];
                     // other preambles leave the selection
                  end
                  default:
                     sda_oe_n <= 1'b1; // master acks read bytes
               endcase
            end
            else if (i2c_q == I_RDAT && tx_cnt_q != `AMCS_RES_BITS)
               sda_oe_n <= tx_q[23]; // release for one, pull for zero
            else
               sda_oe_n <= 1'b1;
         end
      end
   end

   // wishbone slave: ack one cycle after request, held one cycle
   always @(posedge clk)
   begin
      if (rst)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
         ctrl_q <= `AMCS_CTRL_RESET;
      end
      else
      begin
         wb_ack_o <= wb_req;
         wb_dat_o <= 32'h00000000;
         if (wb_req && wb_we_i && wb_sel_i[0] &&
            wb_adr_i == `AMCS_OFS_CTRL)
            ctrl_q <= {1'b0, wb_dat_i[`AMCS_CTRL_GLOBAL_EN]};
         if (wb_req && !wb_we_i)
         begin
            case (wb_adr_i)
               `AMCS_OFS_CTRL:
                  wb_dat_o <= {30'h00000000, ctrl_q};
               `AMCS_OFS_STATUS:
                  wb_dat_o <= {16'h0000, 1'b0, own_addr_q, 2'h0,
                     addressed_q, buf_valid, 2'h0, dev_q};
               `AMCS_OFS_CHSEL:
                  wb_dat_o <= {27'h0000000, sel_q};
               `AMCS_OFS_RESULT:
                  wb_dat_o <= {8'h00, last_res_q};
               default:
                  wb_dat_o <= 32'h00000000; // unmapped reads zero
            endcase
         end
      end
   end
endmodule // amcs_top

/* hdl/amcs_regs.vh */
// constants for the mux select and conversion sequencer
`ifndef AMCS_REGS_VH
`define AMCS_REGS_VH

// wishbone register byte offsets
`define AMCS_OFS_CTRL    4'h0
`define AMCS_OFS_STATUS  4'h4
`define AMCS_OFS_CHSEL   4'h8
`define AMCS_OFS_RESULT  4'hC

// control register fields
`define AMCS_CTRL_GLOBAL_EN  0
`define AMCS_CTRL_FORCE      1
`define AMCS_CTRL_RESET      2'h1

// channel selection word: {single_ended, odd, index[2:0]}
`define AMCS_SEL_RESET   5'h00
`define AMCS_SEL_SGL     4
`define AMCS_SEL_ODD     3

// input word preamble values
`define AMCS_PRE_LOAD    3'h5

// bus addresses
`define AMCS_GLOBAL_ADDR 7'h77
`define AMCS_ADDR_TABLE_DEF {27{7'h14}}

// result framing
`define AMCS_RES_BITS    5'h18
`define AMCS_BYTE_BITS   4'h8

// strap sense codes
`define AMCS_STRAP_LOW   2'h0
`define AMCS_STRAP_HIGH  2'h1

`endif

/* hdl/amcs_fifo2.v */
// two-entry valid/ready buffer for conversion results
`timescale 1ns/1ps
module amcs_fifo2 #(
   parameter WIDTH = 24
) (
   input wire clk,
   input wire rst,
   input wire in_valid,
   output wire in_ready,
   input wire [WIDTH-1:0] in_data,
   output wire out_valid,
   input wire out_ready,
   output wire [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] mem_q [0:1]; // storage words
   reg wr_ptr_q; // write slot
   reg rd_ptr_q; // read slot
   reg [1:0] count_q; // words held
   reg rdy_q; // room flag, registered so ready comes from a flop
   wire push; // word accepted
   wire pop; // word drained

   assign in_ready = rdy_q;
   assign out_valid = (count_q != 2'h0);
   assign out_data = mem_q[rd_ptr_q];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   // storage write, no reset needed on data
   always @(posedge clk)
   begin
      if (push)
         mem_q[wr_ptr_q] <= in_data;
   end

   // pointers and occupancy
   always @(posedge clk)
   begin
      if (rst)
      begin
         wr_ptr_q <= 1'b0;
         rd_ptr_q <= 1'b0;
         count_q <= 2'h0;
         rdy_q <= 1'b1;
      end
      else
      begin
         if (push)
            wr_ptr_q <= ~wr_ptr_q;
         if (pop)
            rd_ptr_q <= ~rd_ptr_q;
         if (push & ~pop)
            count_q <= count_q + 2'h1;
         else if (pop & ~push)
            count_q <= count_q - 2'h1;
         // room flag follows the occupancy it is about to have
         if (push & ~pop)
            rdy_q <= (count_q == 2'h0);
         else if (pop & ~push)
            rdy_q <= 1'b1;
      end
   end
endmodule // amcs_fifo2

/* hdl/amcs_mux_dec.v */
// decodes the five-bit channel selection into one-hot mux enables
`timescale 1ns/1ps
`include "amcs_regs.vh"
module amcs_mux_dec (
   input wire [4:0] sel,
   output reg [16:0] pos_en,
   output reg [16:0] neg_en
);
   reg [3:0] even_ch; // channel 2n
   reg [3:0] pos_ch; // positive channel number
   reg [3:0] neg_ch; // negative channel number

   // bit 16 of each vector is the shared return input
   always @*
   begin
      even_ch = {sel[2:0], 1'b0};
      pos_ch = even_ch | {3'h0, sel[`AMCS_SEL_ODD]};
      neg_ch = even_ch | {3'h0, ~sel[`AMCS_SEL_ODD]};
      pos_en = 17'h00000;
      neg_en = 17'h00000;
      pos_en[pos_ch] = 1'b1;
      if (sel[`AMCS_SEL_SGL])
         neg_en[16] = 1'b1; // single-ended: return is negative
      else
         neg_en[neg_ch] = 1'b1; // pair, swapped when odd set
   end
endmodule // amcs_mux_dec

/* verification/amcs_top_sva.sv */
// assertion checker for the sequencer, bound to its top module
`timescale 1ns/1ps
module amcs_top_chk (
   input wire clk,
   input wire rst,
   input wire scl_i,
   input wire sda_o,
   input wire sda_oe_n,
   input wire conv_start,
   input wire [16:0] mux_pos_en,
   input wire [16:0] mux_neg_en,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_ack_o
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   wire [16:0] both = mux_pos_en | mux_neg_en; // selected inputs
   // request answered one cycle later
   AST_WB_ACK:
      assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus request not answered");
   // ack is a single-cycle pulse
   AST_WB_PULSE:
      assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   // conversion start is a single-cycle pulse
   AST_CONV_PULSE:
      assert property (conv_start |=> !conv_start) else $error("long start");
   // first start after reset: channel 0 plus, channel 1 minus
   AST_RESET_SEL:
      assert property ($fell(rst) |=> conv_start && mux_pos_en == 17'h00001
         && mux_neg_en == 17'h00002) else $error("wrong reset selection");
   // one plus and one minus input, return never plus
   AST_MUX_ONE:
      assert property (conv_start |-> $onehot(mux_pos_en)
         && $onehot(mux_neg_en) && !mux_pos_en[16])
      else $error("mux enables not one-hot");
   // differential inputs form an aligned even/odd pair
   AST_MUX_PAIR:
      assert property (conv_start && !mux_neg_en[16] |->
         (both & 17'h0AAAA) == ((both & 17'h05555) << 1))
      else $error("differential pair misaligned");
   // data line only ever pulled low
   AST_SDA_LOW:
      assert property (!sda_o) else $error("data driven high");
   // slave takes the data line only while the clock is low
   AST_OE_TAKE:
      assert property ($fell(sda_oe_n) |-> !scl_i && !$past(scl_i))
      else $error("data taken while clock high");
   // slave output stands for three cycles from each clock rise
   AST_OE_HOLD:
      assert property ($rose(scl_i) |-> $stable(sda_oe_n) [*3])
      else $error("data changed while clock high");
   cover property (conv_start);
   cover property (wb_ack_o);
   cover property ($fell(sda_oe_n));
endmodule // amcs_top_chk

bind amcs_top amcs_top_chk u_chk (.clk(clk), .rst(rst), .scl_i(scl_i),
   .sda_o(sda_o), .sda_oe_n(sda_oe_n), .conv_start(conv_start),
   .mux_pos_en(mux_pos_en), .mux_neg_en(mux_neg_en), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o));

/* verification/amcs_bus_master.sv */
// two-wire bus master model; a released data line reads high
`timescale 1ns/1ps
module amcs_bus_master (
   input wire clk,
   input wire sda_line,
   output reg scl = 1'b1,
   output reg sda_m = 1'b1
);
   // a third of one bus clock
   task hp;
      repeat (4) @(posedge clk);
   endtask
   // start: data falls while clock high
   task start;
      sda_m <= 1'b0;
      hp;
      scl <= 1'b0;
   endtask
   // stop, only after an acknowledge slot
   task stop;
      hp;
      sda_m <= 1'b0;
      hp;
      scl <= 1'b1;
      hp;
      sda_m <= 1'b1;
      hp;
   endtask
   // one clock: data set while low, sampled late in high
   task bit1(input b, output r);
      hp;
      sda_m <= b;
      hp;
      scl <= 1'b1;
      hp;
      r = sda_line;
      scl <= 1'b0;
   endtask
   // eight bits msb first, then the acknowledge slot
   task xfer(input [7:0] d, input am, output [7:0] r, output ak);
      integer i;
      for (i = 7; i >= 0; i = i - 1)
         bit1(d[i], r[i]);
      bit1(am, ak);
   endtask
endmodule // amcs_bus_master

/* verification/amcs_tb_top.sv */
// self-checking bench for the mux select and conversion sequencer
`timescale 1ns/1ps
module amcs_tb_top;
   localparam [6:0] DEV = 7'h29; // strap row 11
   localparam [188:0] TBL = {{15{7'h14}}, DEV, {11{7'h14}}};
   localparam [19:0] SELS = {5'h04, 5'h1C, 5'h13, 5'h0B};
   reg clk, a;
   reg rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, hold = 1'b1;
   reg res_valid = 1'b0;
   reg [17:0] res = 18'h2A5C3; // sign, over-range, value
   reg [3:0] adr = 4'h0;
   reg [31:0] wdat = 32'h0, rd;
   reg [7:0] cnt = 8'h00, n_conv = 8'h00, c, rb, b0, b1, b2;
   wire scl, sda_m, sda_o, sda_oe_n, conv_start, res_ready, pflag, ack;
   wire [16:0] pos, neg;
   wire [31:0] dat_o;
   wire sda_line = sda_m & (sda_oe_n | sda_o); // pulled up when free
   integer mismatches = 0, total_checks = 0, i, k;
   amcs_top #(.ADDR_TABLE(TBL)) dut (.clk(clk), .rst(rst),
      .addr_strap_0(2'h2), .addr_strap_1(2'h0), .addr_strap_2(2'h1),
      .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
      .conv_start(conv_start), .res_valid(res_valid),
      .res_ready(res_ready), .res_sign(res[17]), .res_ovr(res[16]),
      .res_value(res[15:0]), .mux_pos_en(pos), .mux_neg_en(neg),
      .polarity_flag_out(pflag), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
      .wb_dat_o(dat_o), .wb_ack_o(ack));
   amcs_bus_master m (.clk(clk), .sda_line(sda_line), .scl(scl),
      .sda_m(sda_m));
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // converter stand-in: result some cycles after each start
   always @(posedge clk)
      if (conv_start)
         cnt <= 8'h14;
      else if (cnt != 8'h00 && !hold)
         cnt <= cnt - 8'h01;
   always @(posedge clk)
      if (rst || (res_valid && res_ready))
         res_valid <= 1'b0;
      else if (cnt == 8'h01 && !hold)
         res_valid <= 1'b1;
   always @(posedge clk)
      if (conv_start)
         n_conv <= n_conv + 8'h01;
   // expected {plus, minus} enables of a selection
   function [33:0] exp_mux(input [4:0] s);
      reg [16:0] p;
      p = 17'h00001 << {s[2:0], 1'b0};
      if (s[4])
         exp_mux = {p << s[3], 17'h10000};
      else if (s[3])
         exp_mux = {p << 1, p};
      else
         exp_mux = {p, p << 1};
   endfunction
   task chk(input [33:0] got, input [33:0] exp);
      total_checks = total_checks + 1;
      if (got !== exp)
      begin
         mismatches = mismatches + 1;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // one classic bus cycle, held until ack
   task wb(input w, input [3:0] ad, input [31:0] d);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= ad;
      wdat <= d;
      @(posedge clk);
      while (ack !== 1'b1)
         @(posedge clk);
      rd = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task wait_sleep;
      k = 0;
      wb(1'b0, 4'h4, 32'h0);
      while (rd[1:0] !== 2'h1 && k < 60)
      begin
         wb(1'b0, 4'h4, 32'h0);
         k = k + 1;
      end
      chk(rd[1:0], 2'h1);
   endtask
   // input word, then stop to start a conversion
   task wr_sel(input [7:0] w);
      wait_sleep;
      m.start;
      m.xfer({DEV, 1'b0}, 1'b1, rb, a);
      chk(a, 1'b0);
      m.xfer(w, 1'b1, rb, a);
      m.stop;
      repeat (3) @(posedge clk);
   endtask
   // full read; the last acknowledge slot restarts
   task t_read(input [4:0] s);
      wait_sleep;
      wb(1'b0, 4'hC, 32'h0);
      chk(rd, {8'h00, res, 6'h00});
      c = n_conv;
      m.start;
      m.xfer({DEV, 1'b1}, 1'b1, rb, a);
      chk(a, 1'b0);
      m.xfer(8'hFF, 1'b0, b0, a);
      m.xfer(8'hFF, 1'b0, b1, a);
      m.xfer(8'hFF, 1'b1, b2, a);
      repeat (2) @(posedge clk);
      chk({b0, b1, b2}, {res, 6'h00});
      chk(n_conv, c + 8'h01);
      chk({pos, neg}, exp_mux(s));
      chk(pflag, res[17]);
      m.stop;
   endtask
   task t_sel;
      for (i = 0; i < 4; i = i + 1)
      begin
         wr_sel({3'h5, SELS[i*5 +: 5]});
         chk({pos, neg}, exp_mux(SELS[i*5 +: 5]));
      end
      wr_sel(8'h1F);
      chk({pos, neg}, exp_mux(5'h04));
      wr_sel(8'h95);
      chk({pos, neg}, exp_mux(5'h04));
   endtask
   // wrong address refused, global address starts a conversion
   task t_global;
      wait_sleep;
      m.start;
      m.xfer({7'h14, 1'b1}, 1'b1, rb, a);
      chk(a, 1'b1);
      m.stop;
      wb(1'b1, 4'h0, 32'h0);
      m.start;
      m.xfer({7'h77, 1'b0}, 1'b1, rb, a);
      chk(a, 1'b1);
      m.stop;
      wb(1'b1, 4'h0, 32'h1);
      c = n_conv;
      m.start;
      m.xfer({7'h77, 1'b0}, 1'b1, rb, a);
      chk(a, 1'b0);
      m.stop;
      repeat (3) @(posedge clk);
      chk(n_conv, c + 8'h01);
   endtask
   // one byte read, abort in the acknowledge slot
   task t_abort;
      wait_sleep;
      c = n_conv;
      m.start;
      m.xfer({DEV, 1'b1}, 1'b1, rb, a);
      m.xfer(8'hFF, 1'b1, b0, a);
      chk(b0, res[17:10]);
      m.stop;
      repeat (3) @(posedge clk);
      chk(n_conv, c + 8'h01);
   endtask
   task test_done;
      if (mismatches == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial
   begin
      repeat (60000) @(posedge clk);
      mismatches = mismatches + 1;
      test_done;
   end
   initial
   begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      chk(n_conv, 8'h01);
      chk({pos, neg}, exp_mux(5'h00));
      wb(1'b0, 4'h0, 32'h0);
      chk(rd, 32'h1);
      wb(1'b0, 4'h4, 32'h0);
      chk(rd[14:8], DEV);
      wb(1'b0, 4'h1, 32'h0);
      chk(rd, 32'h0);
      m.start;
      m.xfer({DEV, 1'b1}, 1'b1, rb, a);
      chk(a, 1'b1);
      m.stop;
      hold <= 1'b0;
      t_read(5'h00);
      t_sel;
      t_read(5'h04);
      t_global;
      t_abort;
      wait_sleep;
      wb(1'b1, 4'h8, 32'h1A);
      wb(1'b1, 4'h0, 32'h3);
      repeat (3) @(posedge clk);
      chk({pos, neg}, exp_mux(5'h1A));
      test_done;
   end
endmodule // amcs_tb_top
